// ---- testbench/removable_media_lock_control_test.sv ----
// Self-checking bench for the media lock control block
`timescale 1ns/1ps
module removable_media_lock_control_test;
   import rmlc_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic media_present = 1'b1;
   logic change_button = 1'b0;
   logic device_fault = 1'b0;
   rmlc_apb_req_t apb_req;
   rmlc_apb_rsp_t apb_rsp;
   logic media_locked, eject_pulse, busy_out, er;
   logic [31:0] rd;
   int mismatches = 0;
   int checks_done = 0;
   int ejects = 0;
   initial forever #10 clk = ~clk;
   always @(posedge clk) if (eject_pulse === 1'b1) ejects++;
   rmlc_top dut (.clk(clk), .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .media_present(media_present), .change_button(change_button),
      .device_fault(device_fault), .media_locked(media_locked),
      .eject_pulse(eject_pulse), .busy_out(busy_out));
   rmlc_host host (.clk(clk), .req(apb_req), .rsp(apb_rsp));
   task automatic close_out;
      if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, {24'h0, d}, rd, er);
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      host.xfer(1'b0, a, BUS_ZERO, rd, er);
      cmp(rd, {24'h0, e});
   endtask
   // Status is only read after the one-cycle busy window has closed
   task automatic cmd(input logic [7:0] op, input logic [7:0] st, input logic [7:0] fl);
      wr(ADDR_COMMAND, op);
      rc(ADDR_STATE, st);
      rc(ADDR_FAULT, fl);
   endtask
   task automatic t_reset;
      rc(ADDR_STATE, 8'h40);
      rc(ADDR_CONFIG, 8'h02);
      rc(ADDR_LOCK, 8'h00);
      host.xfer(1'b0, 8'h18, BUS_ZERO, rd, er);
      cmp({31'h0, er}, 32'h1);
   endtask
   task automatic t_lock;
      cmd(OP_LOCK, 8'h40, 8'h00);
      cmd(OP_LOCK, 8'h40, 8'h00);
      rc(ADDR_LOCK, 8'h01);
      cmd(OP_UNLOCK, 8'h40, 8'h00);
      rc(ADDR_LOCK, 8'h00);
   endtask
   task automatic t_button;
      cmd(OP_LOCK, 8'h40, 8'h00);
      change_button <= 1'b1;
      repeat (6) @(posedge clk);
      change_button <= 1'b0;
      repeat (6) @(posedge clk);
      rc(ADDR_STATE, 8'h41);
      rc(ADDR_FAULT, 8'h08);
      cmd(OP_LOCK, 8'h41, 8'h08);
      cmd(OP_UNLOCK, 8'h40, 8'h00);
      cmp(ejects, 32'h1);
      rc(ADDR_LOCK, 8'h00);
   endtask
   task automatic t_misc;
      media_present <= 1'b0;
      repeat (6) @(posedge clk);
      cmd(OP_LOCK, 8'h41, 8'h02);
      cmd(OP_UNLOCK, 8'h41, 8'h02);
      media_present <= 1'b1;
      device_fault <= 1'b1;
      repeat (6) @(posedge clk);
      cmd(OP_UNLOCK, 8'h60, 8'h00);
      device_fault <= 1'b0;
      wr(ADDR_CONFIG, 8'h00);
      cmd(OP_LOCK, 8'h41, 8'h04);
      wr(ADDR_CONFIG, 8'h06);
      cmd(OP_UNLOCK, 8'h41, 8'h04);
      wr(ADDR_UNIT_SELECT, 8'h10);
      rc(ADDR_UNIT_SELECT, 8'h10);
      wr(ADDR_CONFIG, 8'h02);
      wr(ADDR_COMMAND, OP_LOCK);
      rc(ADDR_LOCK, 8'h00);
      wr(ADDR_UNIT_SELECT, 8'h00);
   endtask
   task automatic t_notify;
      wr(ADDR_CONFIG, 8'h03);
      cmd(OP_LOCK, 8'h40, 8'h00);
      rc(ADDR_LOCK, 8'h00);
      wr(ADDR_CONFIG, 8'h02);
      cmd(OP_LOCK, 8'h40, 8'h00);
      wr(ADDR_CONFIG, 8'h03);
      cmd(OP_UNLOCK, 8'h40, 8'h00);
      rc(ADDR_LOCK, 8'h01);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset;
      t_lock;
      t_button;
      t_misc;
      t_notify;
      close_out;
   end
   initial begin
      #200000;
      mismatches++;
      close_out;
   end
endmodule
bind rmlc_top rmlc_props props (.clk(clk), .sys_rst(sys_rst), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .media_locked(media_locked), .eject_pulse(eject_pulse),
   .busy_out(busy_out));

// ---- testbench/rmlc_host.sv ----
// Host model issuing APB transfers to the lock control block
`timescale 1ns/1ps
module rmlc_host import rmlc_pkg::*; (
   // Clock
   input wire logic clk,
   // APB master side
   output rmlc_apb_req_t req,
   input wire rmlc_apb_rsp_t rsp
);
   initial req = '0;
   // Waits for ready without assuming latency; the bench watchdog ends a hang
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      do @(posedge clk); while (rsp.pready !== 1'b1);
      r = rsp.prdata;
      e = rsp.pslverr;
      req <= '0;
   endtask
endmodule

// ---- testbench/rmlc_props.sv ----
// Port-level checks for the media lock control block
`timescale 1ns/1ps
module rmlc_props import rmlc_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Bus and mechanism
   input wire rmlc_apb_req_t apb_req,
   input wire rmlc_apb_rsp_t apb_rsp,
   input wire logic media_locked,
   input wire logic eject_pulse,
   input wire logic busy_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic st_rd;
   assign st_rd = apb_rsp.pready && apb_req.penable && !apb_req.pwrite
      && apb_req.paddr == ADDR_STATE;
   property p_busy; $rose(busy_out) |=> !busy_out; endproperty
   a_busy: assert property (p_busy) else $error("busy not one cycle");
   property p_lock; $changed(media_locked) |-> $past(busy_out); endproperty
   a_lock: assert property (p_lock) else $error("lock moved without command");
   property p_eject; eject_pulse |-> $past(busy_out) && !media_locked; endproperty
   a_eject: assert property (p_eject) else $error("eject outside unlock");
   property p_eject1; eject_pulse |=> !eject_pulse; endproperty
   a_eject1: assert property (p_eject1) else $error("eject too long");
   property p_wait; apb_req.psel && $rose(apb_req.penable) |=> apb_rsp.pready; endproperty
   a_wait: assert property (p_wait) else $error("bus answer late");
   property p_pulse; apb_rsp.pready |=> !apb_rsp.pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready too long");
   property p_xfer; st_rd |-> !apb_rsp.prdata[ST_XFER]; endproperty
   a_xfer: assert property (p_xfer) else $error("transfer flag set");
   property p_done; st_rd && !apb_rsp.prdata[ST_BUSY] |-> apb_rsp.prdata[ST_READY]; endproperty
   a_done: assert property (p_done) else $error("ready flag clear");
   c_eject: cover property (eject_pulse);
   c_lock: cover property ($rose(media_locked));
   c_err: cover property (apb_rsp.pslverr);
endmodule

// ---- verilog/rmlc_pkg.sv ----
// Package with register map, bit positions and types for the media lock control block
package rmlc_pkg;
   // Register word addresses on APB (byte addresses)
   localparam logic [7:0] ADDR_COMMAND = 8'h00;
   localparam logic [7:0] ADDR_UNIT_SELECT = 8'h04;
   localparam logic [7:0] ADDR_STATE = 8'h08;
   localparam logic [7:0] ADDR_FAULT = 8'h0c;
   localparam logic [7:0] ADDR_CONFIG = 8'h10;
   localparam logic [7:0] ADDR_LOCK = 8'h14;
   // Opcodes
   localparam logic [7:0] OP_LOCK = 8'hde;
   localparam logic [7:0] OP_UNLOCK = 8'hdf;
   // Bit positions of completion_state_bits
   localparam int ST_BUSY = 7;
   localparam int ST_READY = 6;
   localparam int ST_FAULT = 5;
   localparam int ST_XFER = 3;
   localparam int ST_FAIL = 0;
   // Bit positions of completion_fault_bits
   localparam int ER_EJECT = 3;
   localparam int ER_ABORT = 2;
   localparam int ER_ABSENT = 1;
   // Unit select bit position
   localparam int UNIT_BIT = 4;
   // Config register fields
   localparam int CF_NOTIFY = 0;
   localparam int CF_SUPPORT = 1;
   localparam int CF_PACKET = 2;
   localparam int CF_UNIT_ID = 3;
   localparam logic [7:0] CONFIG_RESET = 8'h02;
   // Lock register fields
   localparam int LK_LOCKED = 0;
   localparam int LK_CHANGE = 1;
   localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      RMLC_IDLE = 2'b00,
      RMLC_EXEC = 2'b01,
      RMLC_DONE = 2'b10
   } rmlc_phase_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } rmlc_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } rmlc_apb_rsp_t;

   typedef struct packed {
      rmlc_phase_t phase;
      logic is_unlock;
      logic [7:0] unit_sel;
      logic [7:0] state_bits;
      logic [7:0] fault_bits;
      logic [7:0] config_bits;
      logic locked;
      logic change_req;
      logic eject;
      logic [2:0] sync_media;
      logic [2:0] sync_button;
      logic [1:0] sync_fault;
      rmlc_apb_rsp_t rsp;
   } rmlc_state_t;
endpackage

// ---- verilog/rmlc_top.sv ----
// Lock and unlock command handling for a removable-media device, APB register slave
`timescale 1ns/1ps
module rmlc_top (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // APB slave
   input wire rmlc_pkg::rmlc_apb_req_t apb_req,
   output rmlc_pkg::rmlc_apb_rsp_t apb_rsp,
   // Drive-side pins
   input wire logic media_present,
   input wire logic change_button,
   input wire logic device_fault,
   // Mechanism control
   output logic media_locked,
   output logic eject_pulse,
   output logic busy_out
);
   import rmlc_pkg::*;

   rmlc_state_t s_q;
   rmlc_state_t s_d;

   logic wr_acc;
   logic rd_acc;
   logic opcode_hit;
   logic selected;
   logic button_rise;
   logic [7:0] err;

   function automatic logic [31:0] widen(input logic [7:0] v);
      widen = {24'h00_0000, v};
   endfunction

   always_comb begin
      s_d = s_q;
      err = 8'h00;
      s_d.sync_media = {s_q.sync_media[1:0], media_present};
      s_d.sync_button = {s_q.sync_button[1:0], change_button};
      s_d.sync_fault = {s_q.sync_fault[0], device_fault};
      // Edge detect only on stages past the first synchroniser flop
      button_rise = s_q.sync_button[1] & ~s_q.sync_button[2];
      s_d.eject = 1'b0;
      s_d.rsp.pready = 1'b0;
      s_d.rsp.pslverr = 1'b0;
      // Writes commit at the edge where the master samples pready high
      wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite & s_q.rsp.pready;
      rd_acc = apb_req.psel & apb_req.penable & ~apb_req.pwrite & ~s_q.rsp.pready;
      // Unit select bit must match the config unit ID bit for this device to take commands
      selected = s_q.unit_sel[UNIT_BIT] == s_q.config_bits[CF_UNIT_ID];
      opcode_hit = 1'b0;

      // Change-request latch: the unlock clear below wins over this hardware set
      if (button_rise && s_q.locked) begin
         s_d.change_req = 1'b1;
      end

      if (apb_req.psel && apb_req.penable && !s_q.rsp.pready) begin
         s_d.rsp.pready = 1'b1;
         s_d.rsp.prdata = BUS_ZERO;
         if (apb_req.pwrite) begin
            case (apb_req.paddr)
               ADDR_COMMAND, ADDR_UNIT_SELECT, ADDR_CONFIG: ;
               ADDR_STATE, ADDR_FAULT, ADDR_LOCK: ;
               default: s_d.rsp.pslverr = 1'b1;
            endcase
         end else if (rd_acc) begin
            case (apb_req.paddr)
               ADDR_UNIT_SELECT: s_d.rsp.prdata = widen(s_q.unit_sel);
               ADDR_STATE: s_d.rsp.prdata = widen(s_q.state_bits);
               ADDR_FAULT: s_d.rsp.prdata = widen(s_q.fault_bits);
               ADDR_CONFIG: s_d.rsp.prdata = widen(s_q.config_bits);
               ADDR_LOCK: s_d.rsp.prdata = widen({6'h00, s_q.change_req, s_q.locked});
               ADDR_COMMAND: s_d.rsp.prdata = BUS_ZERO;
               default: s_d.rsp.pslverr = 1'b1;
            endcase
         end
      end

      if (wr_acc) begin
         case (apb_req.paddr)
            ADDR_COMMAND: begin
               // A new opcode while busy is dropped; host waits for ready
               if (s_q.phase != RMLC_EXEC && selected) begin
                  if (apb_req.pwdata[7:0] == OP_LOCK || apb_req.pwdata[7:0] == OP_UNLOCK) begin
                     opcode_hit = 1'b1;
                  end
               end
            end
            ADDR_UNIT_SELECT: s_d.unit_sel = apb_req.pwdata[7:0];
            ADDR_CONFIG: s_d.config_bits = apb_req.pwdata[7:0];
            default: ;
         endcase
      end

      // Button while locked, outside RMLC_EXEC, raises eject request and failure summary at once
      if (button_rise && s_q.locked && s_q.phase != RMLC_EXEC) begin
         s_d.fault_bits[ER_EJECT] = 1'b1;
         s_d.state_bits[ST_FAIL] = 1'b1;
      end

      case (s_q.phase)
         RMLC_IDLE, RMLC_DONE: begin
            if (opcode_hit) begin
               s_d.phase = RMLC_EXEC;
               s_d.is_unlock = apb_req.pwdata[0];
               s_d.state_bits = 8'h00;
               s_d.state_bits[ST_BUSY] = 1'b1;
               s_d.fault_bits = 8'h00;
            end
         end
         RMLC_EXEC: begin
            // Outcome settles in one cycle, status and busy drop together
            if (!s_q.config_bits[CF_SUPPORT] || s_q.config_bits[CF_PACKET]) begin
               err[ER_ABORT] = 1'b1;
            end else if (s_q.config_bits[CF_NOTIFY]) begin
               err = 8'h00;
            end else if (!s_q.sync_media[2]) begin
               err[ER_ABSENT] = 1'b1;
            end else if (!s_q.is_unlock) begin
               if (!s_q.locked) begin
                  s_d.locked = 1'b1;
               end else begin
                  // Single bit: relock adds no level
                  err[ER_EJECT] = s_q.change_req | (button_rise & s_q.locked);
               end
            end else begin
               s_d.locked = 1'b0;
               if (s_q.change_req) begin
                  s_d.eject = 1'b1;
                  s_d.change_req = 1'b0;
               end
            end
            s_d.fault_bits = err;
            s_d.state_bits = 8'h00;
            s_d.state_bits[ST_READY] = 1'b1;
            s_d.state_bits[ST_FAULT] = s_q.sync_fault[1];
            s_d.state_bits[ST_XFER] = 1'b0;
            s_d.state_bits[ST_FAIL] = |err;
            s_d.state_bits[ST_BUSY] = 1'b0;
            s_d.phase = RMLC_DONE;
         end
         default: s_d.phase = RMLC_IDLE;
      endcase

      if (sys_rst) begin
         s_d = '0;
         s_d.phase = RMLC_IDLE;
         s_d.config_bits = CONFIG_RESET;
         s_d.state_bits[ST_READY] = 1'b1;
         s_d.locked = 1'b0;
         s_d.change_req = 1'b0;
      end
   end

   // Synchronous reset folded into the next-state copy
   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   assign apb_rsp = s_q.rsp;
   assign media_locked = s_q.locked;
   assign eject_pulse = s_q.eject;
   assign busy_out = s_q.state_bits[ST_BUSY];
endmodule
